/* link_partner_ability_capture.sv */
// Link partner ability register with base-page and next-page views.
// Assumes negotiation and management logic run on sys_clk_in; their strobes are one-cycle pulses.
`timescale 1ns/1ps
module link_partner_ability_capture (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic base_page_valid_in,
  input wire logic [partner_ability_pkg::DATA_W-1:0] base_page_word_in,
  input wire logic next_page_valid_in,
  input wire logic [partner_ability_pkg::DATA_W-1:0] next_page_word_in,
  input wire logic np_supported_in,
  input wire logic an_complete_in,
  input wire logic an_restart_in,
  input wire logic [partner_ability_pkg::ADDR_W-1:0] mgmt_addr_in,
  input wire logic mgmt_rd_in,
  input wire logic mgmt_wr_in,
  input wire logic [partner_ability_pkg::DATA_W-1:0] mgmt_wdata_in,
  output logic mgmt_sel_out,
  output logic [partner_ability_pkg::DATA_W-1:0] mgmt_rdata_out,
  output logic [partner_ability_pkg::DATA_W-1:0] partner_ability_word_out,
  output logic next_page_view_out,
  output logic more_pages_request_out,
  output logic partner_ack_out,
  output logic far_fault_flag_out,
  output logic asymmetric_flow_ability_out,
  output logic symmetric_pause_out,
  output logic t4_ability_out,
  output logic fast_full_duplex_ability_out,
  output logic fast_half_duplex_ability_out,
  output logic slow_full_duplex_ability_out,
  output logic slow_half_duplex_ability_out,
  output logic [partner_ability_pkg::SEL_HI:0] selector_out,
  output logic message_page_flag_out,
  output logic comply_ability_flag_out,
  output logic toggle_out,
  output logic [partner_ability_pkg::CODE_HI:0] code_field_out
);
  import partner_ability_pkg::*;

  logic [DATA_W-1:0] base_q;
  logic [DATA_W-1:0] next_q;
  logic [DATA_W-1:0] view_r;
  logic [DATA_W-1:0] view_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic show_next;
  logic show_next_r;
  logic addr_hit;
  view_state_t state_r;
  view_state_t state_nxt;

  // Base page store, reserved bit forced to zero
  word_capture #(
    .WIDTH(DATA_W),
    .KEEP_MASK(BASE_KEEP_MASK)
  ) u_base (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .load_in(base_page_valid_in),
    .word_in(base_page_word_in),
    .word_out(base_q)
  );

  // Next page store
  word_capture #(
    .WIDTH(DATA_W),
    .KEEP_MASK(NEXT_KEEP_MASK)
  ) u_next (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .load_in(next_page_valid_in),
    .word_in(next_page_word_in),
    .word_out(next_q)
  );

  // View selection; a capture in the restart cycle wins, except an unsupported next page in the base view
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      VIEW_EMPTY: begin
        if (base_page_valid_in) begin
          state_nxt = VIEW_BASE;
        end
      end
      VIEW_BASE: begin
        if (next_page_valid_in && np_supported_in) begin
          state_nxt = VIEW_NEXT;
        end else if (an_restart_in && !base_page_valid_in) begin
          state_nxt = VIEW_EMPTY;
        end
      end
      VIEW_NEXT: begin
        if (base_page_valid_in) begin
          state_nxt = VIEW_BASE;
        end else if (an_restart_in && !next_page_valid_in) begin
          state_nxt = VIEW_EMPTY;
        end
      end
      default: begin
        state_nxt = VIEW_EMPTY;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      state_r <= VIEW_EMPTY;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Next-page word replaces base contents only after successful negotiation
  assign show_next = (state_r == VIEW_NEXT) && an_complete_in && np_supported_in;

  always_comb begin
    view_nxt = show_next ? next_q : (base_q & BASE_KEEP_MASK);
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      view_r <= WORD_RESET;
      show_next_r <= 1'b0;
    end else begin
      view_r <= view_nxt;
      show_next_r <= show_next;
    end
  end

  // Management read port; writes are accepted and discarded
  assign addr_hit = (mgmt_addr_in == PARTNER_ABILITY_ADDR);
  assign mgmt_sel_out = addr_hit;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      rdata_r <= WORD_RESET;
    end else if (mgmt_rd_in) begin
      rdata_r <= addr_hit ? view_r : WORD_RESET;
    end
  end

  assign mgmt_rdata_out = rdata_r;
  assign partner_ability_word_out = view_r;
  assign next_page_view_out = show_next_r;

  // Base-page view fields
  assign more_pages_request_out = view_r[MORE_PAGES_BIT];
  assign partner_ack_out = view_r[ACK_BIT];
  assign far_fault_flag_out = !show_next_r && view_r[FAR_FAULT_BIT];
  assign asymmetric_flow_ability_out = !show_next_r && view_r[ASYM_PAUSE_BIT];
  assign symmetric_pause_out = !show_next_r && view_r[SYM_PAUSE_BIT];
  assign t4_ability_out = !show_next_r && view_r[T4_BIT];
  assign fast_full_duplex_ability_out = !show_next_r && view_r[FAST_FD_BIT];
  assign fast_half_duplex_ability_out = !show_next_r && view_r[FAST_HD_BIT];
  assign slow_full_duplex_ability_out = !show_next_r && view_r[SLOW_FD_BIT];
  assign slow_half_duplex_ability_out = !show_next_r && view_r[SLOW_HD_BIT];
  assign selector_out = show_next_r ? '0 : view_r[SEL_HI:0];

  // Next-page view fields
  assign message_page_flag_out = show_next_r && view_r[MSG_PAGE_BIT];
  assign comply_ability_flag_out = show_next_r && view_r[COMPLY_BIT];
  assign toggle_out = show_next_r && view_r[TOGGLE_BIT];
  assign code_field_out = show_next_r ? view_r[CODE_HI:0] : '0;

  // Checks
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence base_arrives_s;
    base_page_valid_in && !next_page_valid_in;
  endsequence

  sequence base_view_held_s;
    base_arrives_s ##1 !show_next;
  endsequence

  sequence read_hit_s;
    mgmt_rd_in && (mgmt_addr_in == PARTNER_ABILITY_ADDR);
  endsequence

  sequence read_miss_s;
    mgmt_rd_in && (mgmt_addr_in != PARTNER_ABILITY_ADDR);
  endsequence

  sequence next_arrives_s;
    next_page_valid_in && np_supported_in && (state_r == VIEW_BASE);
  endsequence

  sequence next_view_opens_s;
    next_arrives_s ##1 (an_complete_in && np_supported_in && !base_page_valid_in);
  endsequence

  AST_BASE_STORED: assert property (base_view_held_s |=>
    view_r == ($past(base_page_word_in, 2) & BASE_KEEP_MASK))
    else $error("base page word not shown two cycles after capture");

  AST_NEXT_REPLACES: assert property ((state_r == VIEW_NEXT) && an_complete_in && np_supported_in |=>
    view_r == $past(next_q) && show_next_r)
    else $error("next page word not shown after completion");

  AST_NO_EARLY_NEXT: assert property (!an_complete_in |=> !show_next_r)
    else $error("next page view shown before completion");

  AST_NEXT_ENTRY: assert property (next_page_valid_in && np_supported_in && state_r == VIEW_BASE |=>
    state_r == VIEW_NEXT)
    else $error("next page capture did not enter next view");

  AST_RESERVED_ZERO: assert property (!show_next |=> !view_r[RSV_BIT])
    else $error("reserved bit set in base view");

  AST_SELECTOR_TRACK: assert property (base_view_held_s |=>
    selector_out == $past(base_page_word_in[SEL_HI:0], 2))
    else $error("selector field differs from received value");

  AST_FLAGS_TRACK: assert property (base_view_held_s |=>
    more_pages_request_out == $past(base_page_word_in[MORE_PAGES_BIT], 2) &&
    far_fault_flag_out == $past(base_page_word_in[FAR_FAULT_BIT], 2))
    else $error("page request or fault flag differs from received value");

  AST_WRITE_IGNORED: assert property (mgmt_wr_in && !base_page_valid_in && !next_page_valid_in |=>
    $stable(base_q) && $stable(next_q))
    else $error("management write changed a stored word");

  AST_READ_HIT: assert property (read_hit_s |=> mgmt_rdata_out == $past(view_r))
    else $error("read data differs from register view");

  AST_READ_MISS: assert property (read_miss_s |=> mgmt_rdata_out == WORD_RESET)
    else $error("unmapped read returned nonzero data");

  AST_RESET_CLEAR: assert property ($rose(rst_b_in) |-> view_r == WORD_RESET && state_r == VIEW_EMPTY)
    else $error("register not zero after reset");

  AST_NEXT_STORED: assert property (next_view_opens_s |=>
    view_r == $past(next_page_word_in, 2) && next_page_view_out)
    else $error("next page word not shown after entry and completion");

  AST_ACK_TRACK: assert property (base_view_held_s |=>
    partner_ack_out == $past(base_page_word_in[ACK_BIT], 2))
    else $error("acknowledge bit differs from received value");

  AST_FAULT_TRACK: assert property (base_view_held_s |=>
    far_fault_flag_out == $past(base_page_word_in[FAR_FAULT_BIT], 2))
    else $error("remote fault flag differs from received value");

  AST_PAUSE_TRACK: assert property (base_view_held_s |=>
    asymmetric_flow_ability_out == $past(base_page_word_in[ASYM_PAUSE_BIT], 2) &&
    symmetric_pause_out == $past(base_page_word_in[SYM_PAUSE_BIT], 2))
    else $error("pause abilities differ from received value");

  AST_TECH_TRACK: assert property (base_view_held_s |=>
    {t4_ability_out, fast_full_duplex_ability_out, fast_half_duplex_ability_out,
    slow_full_duplex_ability_out, slow_half_duplex_ability_out} ==
    $past(base_page_word_in[T4_BIT:SLOW_HD_BIT], 2))
    else $error("technology abilities differ from received value");

  AST_NEXT_FLAGS: assert property (next_view_opens_s |=>
    more_pages_request_out == $past(next_page_word_in[MORE_PAGES_BIT], 2) &&
    partner_ack_out == $past(next_page_word_in[ACK_BIT], 2))
    else $error("next page request or acknowledge differs from received value");

  AST_NEXT_FIELDS: assert property (next_view_opens_s |=>
    {message_page_flag_out, comply_ability_flag_out, toggle_out, code_field_out} ==
    $past(next_page_word_in[MSG_PAGE_BIT:0], 2))
    else $error("next page fields differ from received value");

  AST_BASE_HIDES_NEXT: assert property (!next_page_view_out |->
    !message_page_flag_out && !comply_ability_flag_out && !toggle_out && code_field_out == '0)
    else $error("next page field shown in base view");

  AST_NEXT_HIDES_BASE: assert property (next_page_view_out |->
    selector_out == '0 && !far_fault_flag_out && !asymmetric_flow_ability_out && !t4_ability_out)
    else $error("base page field shown in next page view");

  AST_RESTART_EMPTY: assert property (an_restart_in && !base_page_valid_in && !next_page_valid_in |=>
    state_r == VIEW_EMPTY)
    else $error("restart did not return the view to empty");

  AST_EMPTY_NO_NEXT: assert property (state_r == VIEW_EMPTY && !base_page_valid_in |=>
    state_r == VIEW_EMPTY && !next_page_view_out)
    else $error("next page view opened without a base page");

  AST_NO_EMPTY_JUMP: assert property (state_r == VIEW_EMPTY |=> state_r != VIEW_NEXT)
    else $error("view jumped from empty to next page");

  AST_NEXT_NEEDS_SUPPORT: assert property (!np_supported_in |=> !next_page_view_out)
    else $error("next page view shown without next page support");

  AST_NEXT_REFUSED: assert property (next_page_valid_in && !np_supported_in &&
    state_r == VIEW_BASE && !an_restart_in |=> state_r == VIEW_BASE)
    else $error("unsupported next page changed the view");

  AST_READ_HOLD: assert property (!mgmt_rd_in |=> $stable(mgmt_rdata_out))
    else $error("read data changed without a read");

  AST_RESERVED_READ: assert property (read_hit_s && !next_page_view_out |=>
    !mgmt_rdata_out[RSV_BIT])
    else $error("reserved bit read as one in base view");

  AST_RESET_FIELDS: assert property ($rose(rst_b_in) |->
    selector_out == '0 && mgmt_rdata_out == WORD_RESET && !next_page_view_out)
    else $error("fields not zero after reset");

  AST_BASE_ENTRY: assert property (base_arrives_s |=> state_r == VIEW_BASE)
    else $error("base page capture did not select base view");

  AST_NEXT_CAPTURE: assert property (next_page_valid_in |=> next_q == $past(next_page_word_in))
    else $error("next page word not stored");

  AST_BASE_CAPTURE: assert property (base_page_valid_in |=>
    base_q == ($past(base_page_word_in) & BASE_KEEP_MASK) && !base_q[RSV_BIT])
    else $error("base page word not stored with reserved bit cleared");
endmodule

/* partner_ability_pkg.sv */
// Constants, field positions and view states for the link partner ability capture.
// Assumes one clock domain shared with the negotiation and management logic.
// Function
// - Store the received partner ability word at management address 05h.
// - With next pages supported, show received next-page word after successful negotiation.
// - Bit 15 shows partner request for further page; resets 0; not writable.
// - Bit 14 shows partner acknowledge, driven only by negotiation logic.
// - Bit 13 shows partner remote fault.
// - Bit 12 reserved, always reads 0 in the base-page view.
// - Bit 11 asymmetric pause, bit 10 symmetric pause of partner.
// - Bits 9..5 show T4, TX full, TX, 10 full, 10 abilities.
// - Bits 4:0 hold received selector; reset zero; read-only.
// - Next-page view bit 15 more pages, bit 14 acknowledge; read-only, reset 0.
// - Next-page view bits 13 message, 12 comply, 11 toggle, 10:0 code.
package partner_ability_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] PARTNER_ABILITY_ADDR = 5'h05;
  localparam logic [DATA_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] BASE_KEEP_MASK = 16'hEFFF;
  localparam logic [DATA_W-1:0] NEXT_KEEP_MASK = 16'hFFFF;
  localparam int MORE_PAGES_BIT = 15;
  localparam int ACK_BIT = 14;
  localparam int FAR_FAULT_BIT = 13;
  localparam int RSV_BIT = 12;
  localparam int ASYM_PAUSE_BIT = 11;
  localparam int SYM_PAUSE_BIT = 10;
  localparam int T4_BIT = 9;
  localparam int FAST_FD_BIT = 8;
  localparam int FAST_HD_BIT = 7;
  localparam int SLOW_FD_BIT = 6;
  localparam int SLOW_HD_BIT = 5;
  localparam int SEL_HI = 4;
  localparam int MSG_PAGE_BIT = 13;
  localparam int COMPLY_BIT = 12;
  localparam int TOGGLE_BIT = 11;
  localparam int CODE_HI = 10;
  typedef enum logic [1:0] {
    VIEW_EMPTY = 2'b00,
    VIEW_BASE = 2'b01,
    VIEW_NEXT = 2'b11
  } view_state_t;
endpackage

/* word_capture.sv */
// Holding register for one received link code word.
// Assumes load_in is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ps
module word_capture #(
  parameter int WIDTH = partner_ability_pkg::DATA_W,
  parameter logic [WIDTH-1:0] KEEP_MASK = partner_ability_pkg::NEXT_KEEP_MASK
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic load_in,
  input wire logic [WIDTH-1:0] word_in,
  output logic [WIDTH-1:0] word_out
);
  import partner_ability_pkg::*;

  logic [WIDTH-1:0] word_r;

  // Loads only from the negotiation side
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      word_r <= WIDTH'(WORD_RESET);
    end else if (load_in) begin
      word_r <= word_in & KEEP_MASK;
    end
  end

  assign word_out = word_r;
endmodule

/* link_partner_model.sv */
// Behavioural remote link partner as seen through the negotiation logic.
// Assumes the design samples its strobes on the rising edge of sys_clk_in.
`timescale 1ns/1ps
module link_partner_model (
  input wire logic sys_clk_in,
  output logic base_valid_out,
  output logic [partner_ability_pkg::DATA_W-1:0] base_word_out,
  output logic next_valid_out,
  output logic [partner_ability_pkg::DATA_W-1:0] next_word_out,
  output logic np_supported_out,
  output logic an_complete_out,
  output logic an_restart_out
);
  initial begin
    base_valid_out = 1'b0;
    base_word_out = 16'h0000;
    next_valid_out = 1'b0;
    next_word_out = 16'h0000;
    np_supported_out = 1'b0;
    an_complete_out = 1'b0;
    an_restart_out = 1'b0;
  end
  // One received page; word line shows junk once the strobe drops
  task automatic send_page(input logic nxt, input logic [15:0] w);
    @(posedge sys_clk_in);
    if (nxt) begin
      next_valid_out <= 1'b1;
      next_word_out <= w;
    end else begin
      base_valid_out <= 1'b1;
      base_word_out <= w;
    end
    @(posedge sys_clk_in);
    next_valid_out <= 1'b0;
    base_valid_out <= 1'b0;
    next_word_out <= ~w;
    base_word_out <= ~w;
  endtask
  task automatic levels(input logic np, input logic done);
    @(posedge sys_clk_in);
    np_supported_out <= np;
    an_complete_out <= done;
  endtask
  task automatic restart();
    @(posedge sys_clk_in);
    an_restart_out <= 1'b1;
    @(posedge sys_clk_in);
    an_restart_out <= 1'b0;
  endtask
endmodule

/* link_partner_ability_capture_bench.sv */
// Self-checking bench for the link partner ability register.
// Assumes the partner model drives the negotiation inputs.
`timescale 1ns/1ps
module link_partner_ability_capture_bench;
  import partner_ability_pkg::*;
  logic sys_clk, rst_b, bv, nv, np, done, rs, rd, wr, sel, nview;
  logic [15:0] bw, nw, wdata, rdata, word, r, w;
  logic [4:0] addr;
  wire [15:0] base_f;
  wire [15:0] next_f;
  logic mp, af, ff, asy, sy, t4, ffd, fhd, sfd, shd, msg, cmp, tg;
  logic [4:0] selv;
  logic [10:0] code;
  int fail_count = 0;
  int tests_run = 0;
  assign base_f = {mp, af, ff, 1'b0, asy, sy, t4, ffd, fhd, sfd, shd, selv[4:0]};
  assign next_f = {mp, af, msg, cmp, tg, code};
  link_partner_model i_link_partner_model (.sys_clk_in(sys_clk), .base_valid_out(bv), .base_word_out(bw),
    .next_valid_out(nv), .next_word_out(nw), .np_supported_out(np), .an_complete_out(done), .an_restart_out(rs));
  link_partner_ability_capture i_link_partner_ability_capture (.sys_clk_in(sys_clk), .rst_b_in(rst_b),
    .base_page_valid_in(bv), .base_page_word_in(bw), .next_page_valid_in(nv), .next_page_word_in(nw),
    .np_supported_in(np), .an_complete_in(done), .an_restart_in(rs), .mgmt_addr_in(addr), .mgmt_rd_in(rd),
    .mgmt_wr_in(wr), .mgmt_wdata_in(wdata), .mgmt_sel_out(sel), .mgmt_rdata_out(rdata),
    .partner_ability_word_out(word), .next_page_view_out(nview), .more_pages_request_out(mp),
    .partner_ack_out(af), .far_fault_flag_out(ff), .asymmetric_flow_ability_out(asy), .symmetric_pause_out(sy),
    .t4_ability_out(t4), .fast_full_duplex_ability_out(ffd), .fast_half_duplex_ability_out(fhd),
    .slow_full_duplex_ability_out(sfd), .slow_half_duplex_ability_out(shd), .selector_out(selv),
    .message_page_flag_out(msg), .comply_ability_flag_out(cmp), .toggle_out(tg), .code_field_out(code));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reg_read(input logic [4:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(posedge sys_clk);
    #1 d = rdata;
  endtask
  task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    wr <= 1'b1;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    rst_b = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 5'h00;
    wdata = 16'h0000;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    reg_read(PARTNER_ABILITY_ADDR, r);
    check(r, WORD_RESET);
    check({word[14:0], sel}, 16'h0001);
    $display("Test reset done");
    for (int i = 0; i < 16; i++) begin
      w = 16'h0001 << i;
      i_link_partner_model.send_page(1'b0, w);
      reg_read(PARTNER_ABILITY_ADDR, r);
      check(r, w & 16'hEFFF);
      check(base_f, w & 16'hEFFF);
      check(next_f, w & 16'hC000);
    end
    $display("Test base fields done");
    i_link_partner_model.send_page(1'b0, 16'hF234);
    reg_write(PARTNER_ABILITY_ADDR, 16'h0DCB);
    reg_read(PARTNER_ABILITY_ADDR, r);
    check(r, 16'hE234);
    reg_read(5'h06, r);
    check({r[14:0], sel}, 16'h0000);
    $display("Test write and unmapped done");
    i_link_partner_model.levels(1'b0, 1'b1);
    i_link_partner_model.send_page(1'b1, 16'hA5C3);
    reg_read(PARTNER_ABILITY_ADDR, r);
    check({r[14:0], nview}, 16'hC468);
    i_link_partner_model.levels(1'b1, 1'b0);
    i_link_partner_model.send_page(1'b1, 16'h5A3C);
    reg_read(PARTNER_ABILITY_ADDR, r);
    check(r, 16'hE234);
    i_link_partner_model.levels(1'b1, 1'b1);
    reg_read(PARTNER_ABILITY_ADDR, r);
    check(r, 16'h5A3C);
    check(next_f, 16'h5A3C);
    check({base_f[15:14], base_f[12:0], nview}, 16'h4001);
    reg_write(PARTNER_ABILITY_ADDR, 16'hFFFF);
    reg_read(PARTNER_ABILITY_ADDR, r);
    check(r, 16'h5A3C);
    i_link_partner_model.levels(1'b1, 1'b0);
    reg_read(PARTNER_ABILITY_ADDR, r);
    check(r, 16'hE234);
    i_link_partner_model.restart();
    reg_read(PARTNER_ABILITY_ADDR, r);
    check(r, 16'hE234);
    i_link_partner_model.levels(1'b1, 1'b1);
    i_link_partner_model.send_page(1'b1, 16'h1234);
    reg_read(PARTNER_ABILITY_ADDR, r);
    check({r[14:0], nview}, 16'hC468);
    i_link_partner_model.send_page(1'b0, 16'hC3E1);
    i_link_partner_model.send_page(1'b1, 16'h3D5A);
    reg_read(PARTNER_ABILITY_ADDR, r);
    check(r, 16'h3D5A);
    check(next_f, 16'h3D5A);
    check({base_f[15:13], base_f[11:0], nview}, 16'h0001);
    $display("Test next page view done");
    wrap_up();
  end
  initial begin
    #(50 * 2000);
    fail_count++;
    wrap_up();
  end
endmodule
